/* verilog/adc_config_register_write.v */
// configuration/calibration register bank with serial write-command decoder
// assumes serial pins arrive asynchronously to sys_clk (sclk well below sys_clk/4)
// Summary of operation
// - two command bytes then data into consecutive registers
// - first byte 0100 plus start address
// - second byte 0000 plus count minus one
// - data bytes arrive most significant bit first
// - zero-point calibrate stores measured input as offset
// - full-scale calibrate stores measured input as gain
// - all configuration except the continuous readout mode lives in the registers
// - config_identity_bias_timeout bits 5-4 factory identity, read-only
// - config_identity_bias_timeout bit 2 reference bias, reset enabled
// - config_identity_bias_timeout bit 0 enables 2^16 sclk-low timeout
// - input data sampled on falling sclk edges
`timescale 1ns/1ns
`include "adc_cfg_regs.vh"

module adc_config_register_write #(
   parameter [1:0]  IDENT_VALUE    = 2'h1,           // arbitrary factory code
   parameter        TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        sclk,
   input  wire        chip_select_n,
   input  wire        din,
   input  wire [23:0] measured_input,
   input  wire        raw_out_of_range,
   input  wire [23:0] raw_conversion,
   output reg  [23:0] conversion_out,
   output reg  [23:0] offset_coeff,
   output reg  [23:0] gain_coeff,
   output reg         reference_bias_enable,
   output reg         readback_sum_enable,
   output reg  [7:0]  config_flag_checksum_filter_delay_out,
   output reg  [7:0]  config_ready_clock_rate_out,
   output reg         continuous_readout,
   output reg         timeout_pulse
);

   // -----------------------------------------------------------------
   // decoder states
   // -----------------------------------------------------------------
   localparam [2:0] ST_OPCODE = 3'b001;
   localparam [2:0] ST_COUNT  = 3'b010;
   localparam [2:0] ST_DATA   = 3'b100;

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   reg [1:0] sclk_sync;
   reg [1:0] cs_sync;
   reg [1:0] din_sync;
   reg       sclk_prev;

   always @(posedge sys_clk) begin
      if (rst) begin
         sclk_sync <= 2'h0;
         cs_sync   <= 2'h3;
         din_sync  <= 2'h0;
         sclk_prev <= 1'b0;
      end else begin
         sclk_sync <= {sclk_sync[0], sclk};
         cs_sync   <= {cs_sync[0], chip_select_n};
         din_sync  <= {din_sync[0], din};
         sclk_prev <= sclk_sync[1];
      end
   end

   wire sclk_fall = sclk_prev & ~sclk_sync[1];
   wire selected  = ~cs_sync[1];

   // -----------------------------------------------------------------
   // register array
   // -----------------------------------------------------------------
   reg  [7:0] regs [0:`REG_COUNT-1];
   reg  [2:0] state;
   reg  [7:0] shift;
   reg  [2:0] bit_cnt;
   reg  [3:0] addr;
   reg  [3:0] remaining;
   reg  [16:0] low_cnt;

   wire [7:0] next_byte  = {shift[6:0], din_sync[1]};
   wire       byte_done  = selected & sclk_fall & (bit_cnt == 3'h7);
   wire       timeout_on = regs[`REG_CONFIG_IDENTITY_BIAS_TIMEOUT][`CFG0_TIMEOUT_BIT];
   // sclk low long enough counts only while enabled
   wire       timeout_hit = timeout_on & (low_cnt == TIMEOUT_CYCLES - 1) & ~sclk_sync[1];

   // merge keeps read-only bits fixed regardless of written data
   function [7:0] merge;
      input [3:0] a;
      input [7:0] d;
      input [7:0] old;
      begin
         case (a)
            `REG_CONFIG_IDENTITY_BIAS_TIMEOUT: merge = `CFG0_FIXED_VALUE | {2'h0, IDENT_VALUE, 4'h0}
                                  | (d & `CFG0_WRITE_MASK);
            `REG_CONFIG_FLAG_CHECKSUM_FILTER_DELAY: merge = d & `CFG1_WRITE_MASK;
            `REG_CONFIG_READY_CLOCK_RATE: merge = (old & ~`CFG2_WRITE_MASK) | (d & `CFG2_WRITE_MASK);
            default:      merge = d;
         endcase
      end
   endfunction

   // -----------------------------------------------------------------
   // command decoder
   // -----------------------------------------------------------------
   integer i;
   always @(posedge sys_clk) begin
      if (rst) begin
         state              <= ST_OPCODE;
         shift              <= 8'h00;
         bit_cnt            <= 3'h0;
         addr               <= 4'h0;
         remaining          <= 4'h0;
         low_cnt            <= 17'h0_0000;
         timeout_pulse      <= 1'b0;
         continuous_readout <= 1'b1;
         regs[`REG_CONFIG_IDENTITY_BIAS_TIMEOUT] <= `RST_CONFIG_IDENTITY_BIAS_TIMEOUT | {2'h0, IDENT_VALUE, 4'h0};
         regs[`REG_CONFIG_FLAG_CHECKSUM_FILTER_DELAY] <= `RST_CONFIG_FLAG_CHECKSUM_FILTER_DELAY;
         regs[`REG_CONFIG_READY_CLOCK_RATE] <= `RST_CONFIG_READY_CLOCK_RATE;
         regs[`REG_OFFSET_LOW]  <= `RST_OFFSET;
         regs[`REG_OFFSET_MID]  <= `RST_OFFSET;
         regs[`REG_OFFSET_HIGH] <= `RST_OFFSET;
         regs[`REG_GAIN_LOW]    <= `RST_GAIN_OTHER;
         regs[`REG_GAIN_MID]    <= `RST_GAIN_OTHER;
         regs[`REG_GAIN_HIGH]   <= `RST_GAIN_HIGH;
      end else begin
         timeout_pulse <= timeout_hit;
         if (sclk_sync[1] | timeout_hit)
            low_cnt <= 17'h0_0000;
         else
            low_cnt <= low_cnt + 17'h0_0001;

         if (timeout_hit | ~selected) begin
            // abandon partial command
            state   <= ST_OPCODE;
            bit_cnt <= 3'h0;
         end else if (sclk_fall) begin
            shift   <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
               case (state)
                  ST_OPCODE: begin
                     addr <= next_byte[3:0];
                     if (next_byte[7:4] == `CMD_WRITE_PREFIX && !continuous_readout)
                        state <= ST_COUNT;
                     else if (next_byte == `CMD_STOP_CONT)
                        continuous_readout <= 1'b0;
                     else if (next_byte == `CMD_START_CONT)
                        continuous_readout <= 1'b1;
                     else if (next_byte == `CMD_ZERO_CAL && !continuous_readout) begin
                        regs[`REG_OFFSET_LOW]  <= measured_input[7:0];
                        regs[`REG_OFFSET_MID]  <= measured_input[15:8];
                        regs[`REG_OFFSET_HIGH] <= measured_input[23:16];
                     end else if (next_byte == `CMD_FULL_CAL && !continuous_readout) begin
                        regs[`REG_GAIN_LOW]  <= measured_input[7:0];
                        regs[`REG_GAIN_MID]  <= measured_input[15:8];
                        regs[`REG_GAIN_HIGH] <= measured_input[23:16];
                     end
                  end
                  ST_COUNT: begin
                     remaining <= next_byte[3:0];
                     state     <= (next_byte[7:4] == `CMD_COUNT_PREFIX) ? ST_DATA : ST_OPCODE;
                  end
                  ST_DATA: begin
                     for (i = 0; i < `REG_COUNT; i = i + 1) begin
                        if (addr == i[3:0])
                           regs[i] <= merge(addr, next_byte, regs[i]);
                     end
                     addr      <= addr + 4'h1;
                     remaining <= remaining - 4'h1;
                     if (remaining == 4'h0)
                        state <= ST_OPCODE;
                  end
                  default: state <= ST_OPCODE;
               endcase
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // outputs driven from register contents and, for conversion_out, from the raw conversion inputs
   // -----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         offset_coeff          <= {3{`RST_OFFSET}};
         gain_coeff            <= {`RST_GAIN_HIGH, `RST_GAIN_OTHER, `RST_GAIN_OTHER};
         reference_bias_enable <= 1'b1;
         readback_sum_enable   <= 1'b0;
         config_flag_checksum_filter_delay_out           <= `RST_CONFIG_FLAG_CHECKSUM_FILTER_DELAY;
         config_ready_clock_rate_out           <= `RST_CONFIG_READY_CLOCK_RATE;
         conversion_out        <= 24'h00_0000;
      end else begin
         offset_coeff <= {regs[`REG_OFFSET_HIGH], regs[`REG_OFFSET_MID], regs[`REG_OFFSET_LOW]};
         gain_coeff   <= {regs[`REG_GAIN_HIGH], regs[`REG_GAIN_MID], regs[`REG_GAIN_LOW]};
         reference_bias_enable <= regs[`REG_CONFIG_IDENTITY_BIAS_TIMEOUT][`CFG0_BIAS_BIT];
         readback_sum_enable   <= regs[`REG_CONFIG_FLAG_CHECKSUM_FILTER_DELAY][6];
         config_flag_checksum_filter_delay_out           <= regs[`REG_CONFIG_FLAG_CHECKSUM_FILTER_DELAY];
         config_ready_clock_rate_out           <= regs[`REG_CONFIG_READY_CLOCK_RATE];
         if (regs[`REG_CONFIG_FLAG_CHECKSUM_FILTER_DELAY][`CFG1_FLAG_BIT])
            conversion_out <= {raw_conversion[23:1], raw_out_of_range};
         else
            conversion_out <= raw_conversion;
      end
   end

endmodule // adc_config_register_write

/* verilog/adc_cfg_regs.vh */
// register map, field positions, reset values and command codes of the config bank
// assumes inclusion by the config bank module only
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

// -----------------------------------------------------------------
// register offsets (indices)
// -----------------------------------------------------------------
`define REG_CONFIG_IDENTITY_BIAS_TIMEOUT        4'h0
`define REG_CONFIG_FLAG_CHECKSUM_FILTER_DELAY        4'h1
`define REG_CONFIG_READY_CLOCK_RATE        4'h2
`define REG_OFFSET_LOW     4'h3
`define REG_OFFSET_MID     4'h4
`define REG_OFFSET_HIGH    4'h5
`define REG_GAIN_LOW       4'h6
`define REG_GAIN_MID       4'h7
`define REG_GAIN_HIGH      4'h8
`define REG_COUNT          9

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RST_CONFIG_IDENTITY_BIAS_TIMEOUT        8'h85
`define RST_CONFIG_FLAG_CHECKSUM_FILTER_DELAY        8'h08
`define RST_CONFIG_READY_CLOCK_RATE        8'h00
`define RST_OFFSET         8'h00
`define RST_GAIN_HIGH      8'h40
`define RST_GAIN_OTHER     8'h00

// -----------------------------------------------------------------
// fields
// -----------------------------------------------------------------
`define CFG0_FIXED_MASK    8'hc0
`define CFG0_FIXED_VALUE   8'h80
`define CFG0_IDENT_LSB     4
`define CFG0_BIAS_BIT      2
`define CFG0_TIMEOUT_BIT   0
`define CFG0_WRITE_MASK    8'h0f
`define CFG1_FLAG_BIT      7
`define CFG1_WRITE_MASK    8'hdf
`define CFG2_WRITE_MASK    8'h37

// -----------------------------------------------------------------
// commands
// -----------------------------------------------------------------
`define CMD_WRITE_PREFIX   4'h4
`define CMD_COUNT_PREFIX   4'h0
`define CMD_ZERO_CAL       8'h18
`define CMD_FULL_CAL       8'h19
`define CMD_STOP_CONT      8'h11
`define CMD_START_CONT     8'h10

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define TIMEOUT_CYCLES     65536

`endif

/* bench/adc_cfg_chk.sv */
// port-level assertions for the config bank
// assumes binding onto adc_config_register_write
`timescale 1ns/1ns
module adc_cfg_chk #(
   parameter TIMEOUT_CYCLES = 65536
) (
   input wire        sys_clk,
   input wire        rst,
   input wire        sclk,
   input wire        chip_select_n,
   input wire [23:0] raw_conversion,
   input wire        raw_out_of_range,
   input wire [23:0] conversion_out,
   input wire [23:0] offset_coeff,
   input wire [23:0] gain_coeff,
   input wire        reference_bias_enable,
   input wire [7:0]  config_flag_checksum_filter_delay_out,
   input wire [7:0]  config_ready_clock_rate_out,
   input wire        continuous_readout,
   input wire        timeout_pulse
);
   // raw pin count, ahead of the synchronised one while sclk stays low
   reg [16:0] low_cnt;
   always @(posedge sys_clk) begin
      if (rst || sclk) low_cnt <= 17'h0_0000;
      else if (!(&low_cnt)) low_cnt <= low_cnt + 17'h0_0001;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_reset_bias_gain: assert property ($fell(rst) |-> reference_bias_enable && gain_coeff == 24'h40_0000)
      else $error("reset bias or gain wrong");
   a_reset_config_mode: assert property ($fell(rst) |-> config_flag_checksum_filter_delay_out == 8'h08 && config_ready_clock_rate_out == 8'h00
      && offset_coeff == 24'h00_0000 && continuous_readout) else $error("reset config wrong");
   a_flag_lsb_replace: assert property (config_flag_checksum_filter_delay_out[7] [*3] |->
      conversion_out == {$past(raw_conversion[23:1]), $past(raw_out_of_range)}) else $error("flag lsb wrong");
   a_flag_off_pass: assert property (!config_flag_checksum_filter_delay_out[7] [*3] |-> conversion_out == $past(raw_conversion))
      else $error("conversion not passed");
   a_timeout_after_low: assert property (timeout_pulse |-> low_cnt >= TIMEOUT_CYCLES - 1)
      else $error("timeout too early");
   a_timeout_one_cycle: assert property (timeout_pulse |=> !timeout_pulse)
      else $error("timeout pulse too long");
   a_mode_needs_frame: assert property ($changed(continuous_readout) |-> !$past(chip_select_n, 6))
      else $error("mode changed outside frame");
   a_coeff_needs_frame: assert property ($changed(offset_coeff) || $changed(gain_coeff) |->
      !$past(chip_select_n, 6)) else $error("coefficient changed outside frame");
endmodule // adc_cfg_chk

bind adc_config_register_write adc_cfg_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n), .raw_conversion(raw_conversion),
   .raw_out_of_range(raw_out_of_range), .conversion_out(conversion_out), .offset_coeff(offset_coeff),
   .gain_coeff(gain_coeff), .reference_bias_enable(reference_bias_enable), .config_flag_checksum_filter_delay_out(config_flag_checksum_filter_delay_out),
   .config_ready_clock_rate_out(config_ready_clock_rate_out), .continuous_readout(continuous_readout), .timeout_pulse(timeout_pulse));

/* bench/host_serial_model.sv */
// host model driving serial commands into the config bank
// assumes one bench process calls its tasks
`timescale 1ns/1ns
module host_serial_model (
   input  wire sys_clk,
   output reg  sclk,
   output reg  chip_select_n,
   output reg  din
);
   integer i;
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      din = 1'b0;
   end
   task tick(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   task send(input [7:0] b);
      begin
         chip_select_n = 1'b0;
         for (i = 7; i >= 0; i = i - 1) begin
            din = b[i];
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
            tick(4);
         end
      end
   endtask
   // released line flips so a held value never passes
   task done;
      begin
         tick(8);
         chip_select_n = 1'b1;
         din = ~din;
         tick(8);
      end
   endtask
endmodule // host_serial_model

/* bench/adc_config_register_write_tb_top.sv */
// self-checking bench for the config bank
// assumes host_serial_model and the bound checker
`timescale 1ns/1ns
module adc_config_register_write_tb_top;
   localparam TMO = 64;
   reg         sys_clk = 1'b0;
   reg         rst = 1'b1;
   reg         raw_out_of_range = 1'b0;
   reg  [23:0] raw_conversion = 24'h00_0000;
   reg  [23:0] measured_input = 24'h00_0000;
   reg  [23:0] prev_raw, d, cal_ofs;
   reg         prev_oor;
   reg  [7:0]  c1, c2;
   wire        sclk, chip_select_n, din, reference_bias_enable, readback_sum_enable, continuous_readout, timeout_pulse;
   wire [23:0] conversion_out, offset_coeff, gain_coeff;
   wire [7:0]  config_flag_checksum_filter_delay_out, config_ready_clock_rate_out;
   integer     n_errors = 0, num_checks = 0, k, hits = 0;
   always #50 sys_clk = ~sys_clk;
   host_serial_model host (.sys_clk(sys_clk), .sclk(sclk), .chip_select_n(chip_select_n), .din(din));
   adc_config_register_write #(.TIMEOUT_CYCLES(TMO)) dut (
      .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n), .din(din),
      .measured_input(measured_input), .raw_out_of_range(raw_out_of_range), .raw_conversion(raw_conversion),
      .conversion_out(conversion_out), .offset_coeff(offset_coeff), .gain_coeff(gain_coeff),
      .reference_bias_enable(reference_bias_enable), .readback_sum_enable(readback_sum_enable),
      .config_flag_checksum_filter_delay_out(config_flag_checksum_filter_delay_out), .config_ready_clock_rate_out(config_ready_clock_rate_out), .continuous_readout(continuous_readout),
      .timeout_pulse(timeout_pulse));
   always @(posedge sys_clk) begin
      if (timeout_pulse === 1'b1) hits = hits + 1;
      #1 prev_raw = raw_conversion;
      prev_oor = raw_out_of_range;
      raw_conversion = 24'($urandom);
      raw_out_of_range = 1'($urandom);
   end
   function [23:0] conv_exp(input [23:0] raw, input oor, input flag);
      conv_exp = flag ? {raw[23:1], oor} : raw;
   endfunction
   task chk(input [23:0] seen, input [23:0] exp, input [79:0] what);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wr(input [3:0] r, input [3:0] n, input [23:0] v);
      begin
         host.send({4'h4, r});
         host.send({4'h0, n});
         for (k = 0; k <= n; k = k + 1) host.send(v[8*k +: 8]);
         host.done;
      end
   endtask
   task cmd(input [7:0] c);
      begin
         host.send(c);
         host.done;
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #2_000_000;
      n_errors = n_errors + 1;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'h172e));
      repeat (20) @(posedge sys_clk);
      #1 rst = 1'b0;
      host.tick(2);
      chk(offset_coeff, 24'h00_0000, "offset");
      chk(gain_coeff, 24'h40_0000, "gain");
      chk(reference_bias_enable, 1'b1, "bias");
      chk({config_ready_clock_rate_out, config_flag_checksum_filter_delay_out}, 16'h0008, "config");
      // bit 7 set in every byte so refused data never decodes as a command
      d = 24'($urandom) | 24'h80_8080;
      wr(4'h3, 4'h2, d);
      chk(offset_coeff, 24'h00_0000, "refused");
      cmd(8'h11);
      chk(continuous_readout, 1'b0, "mode");
      wr(4'h3, 4'h2, d);
      chk(offset_coeff, d, "offset");
      d = 24'($urandom);
      wr(4'h6, 4'h2, d);
      chk(gain_coeff, d, "gain");
      c1 = 8'($urandom) & 8'hdf | 8'h80;
      c2 = 8'($urandom) & 8'h37;
      wr(4'h0, 4'h2, {c2, c1, 8'h31});
      chk(reference_bias_enable, 1'b0, "bias");
      chk({config_ready_clock_rate_out & 8'h37, config_flag_checksum_filter_delay_out}, {c2, c1}, "config");
      chk(readback_sum_enable, c1[6], "sum");
      repeat (20) begin
         host.tick(1);
         #1;
         chk(conversion_out, conv_exp(prev_raw, prev_oor, 1'b1), "flag");
      end
      measured_input = 24'($urandom);
      cmd(8'h18);
      chk(offset_coeff, measured_input, "zero cal");
      cal_ofs = measured_input;
      measured_input = 24'($urandom);
      cmd(8'h19);
      chk(gain_coeff, measured_input, "full cal");
      hits = 0;
      host.send(8'h46);
      host.tick(3 * TMO);
      // 196 low cycles, 2 sync stages, one pulse per 64 cycles
      chk(hits, 3, "timeout");
      // differs from the present gain low byte, so a missed abandon shows
      d = ~measured_input;
      wr(4'h6, 4'h0, d);
      chk(gain_coeff[7:0], d[7:0], "abandon");
      wr(4'h0, 4'h0, 24'h00_0034);
      hits = 0;
      host.tick(3 * TMO);
      chk(hits, 0, "no timeout");
      chk(reference_bias_enable, 1'b1, "bias");
      cmd(8'h10);
      chk(continuous_readout, 1'b1, "mode");
      measured_input = ~cal_ofs;
      cmd(8'h18);
      chk(offset_coeff, cal_ofs, "refused");
      report_and_stop;
   end
endmodule // adc_config_register_write_tb_top
